// [viu_pkg.sv]
// Constants, register map and state encoding of the vectored interrupt unit.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register master.
package viu_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_REQ = 6;
  localparam int AXI_AW  = 12;
  localparam int IDX_W   = 3;
  localparam int VEC_W   = 16;

  // ----------------------------------------------------------------------
  // Register map: printed offsets are indices, byte address is four times
  // ----------------------------------------------------------------------
  localparam logic [7:0]        IDX_PRIO     = 8'hF9;
  localparam logic [7:0]        IDX_REQ      = 8'hFA;
  localparam logic [7:0]        IDX_MASK     = 8'hFB;
  localparam logic [AXI_AW-1:0] ADDR_PRIO    = {2'b00, IDX_PRIO, 2'b00};
  localparam logic [AXI_AW-1:0] ADDR_REQ     = {2'b00, IDX_REQ, 2'b00};
  localparam logic [AXI_AW-1:0] ADDR_MASK    = {2'b00, IDX_MASK, 2'b00};
  localparam logic [AXI_AW-1:0] ADDR_EVT_STS = 12'h000;
  localparam logic [AXI_AW-1:0] ADDR_EVT_MSK = 12'h004;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int         MASK_GLOBAL_BIT  = 7;
  localparam int         MASK_RAMPROT_BIT = 6;
  localparam logic [7:0] PRIO_RST         = 8'h00;
  localparam logic [5:0] REQ_RST          = 6'h00;
  localparam logic [7:0] MASK_RST         = 8'h00;
  localparam int         EV_W             = 2;
  localparam int         EV_GRANT         = 0;
  localparam int         EV_POLL          = 1;
  localparam logic [1:0] EV_RST           = 2'h0;

  // Source to request mapping
  localparam int PIN0_REQ = 3;
  localparam int PIN1_REQ = 2;
  localparam int PIN2_REQ = 0;
  localparam int PIN3_REQ = 1;
  localparam int TMRA_REQ = 4;
  localparam int TMRB_REQ = 5;

  // RAM protect window: upper half below the control registers
  localparam logic [7:0] RAM_UPPER_LO = 8'h80;
  localparam logic [7:0] CTRL_REG_LO  = 8'hF0;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int         CLOCK_PERIOD_PS  = 10000;
  localparam int         REQ_SETUP_TENTHS = 25;   // 2.5 clock periods
  localparam int         REQ_SETUP_PS     = REQ_SETUP_TENTHS * CLOCK_PERIOD_PS / 10;
  localparam int         SETUP_CYC_I      = (REQ_SETUP_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam logic [1:0] SETUP_CYC        = SETUP_CYC_I[1:0];

  // ----------------------------------------------------------------------
  // Bus responses and grant sequence states
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    VIU_IDLE = 3'b000,
    VIU_DIS  = 3'b001,
    VIU_SAV  = 3'b010,
    VIU_FHI  = 3'b011,
    VIU_FLO  = 3'b100,
    VIU_LOAD = 3'b101,
    VIU_DONE = 3'b110
  } viu_state_t;

endpackage

// [viu_prio.sv]
// Programmable priority encoder for the six requests.
// Assumes eligible requests come from flops on the same clock.
`timescale 1ns/10ps
module viu_prio (
  // Clock and reset, used by the checks only
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // Requests and ordering
  input  wire logic [viu_pkg::NUM_REQ-1:0] pend,
  input  wire logic [viu_pkg::IDX_W-1:0]   first,
  // Winner
  output logic                           win_valid,
  output logic [viu_pkg::IDX_W-1:0]      win_idx
);
  import viu_pkg::*;

  // ----------------------------------------------------------------------
  // Rotating search from the software-chosen first request
  // ----------------------------------------------------------------------
  // Out-of-range start values fall back to request 0 so no request starves
  always_comb begin
    logic [IDX_W-1:0] base;
    logic [IDX_W-1:0] cand;
    base      = (first < IDX_W'(NUM_REQ)) ? first : '0;
    cand      = '0;
    win_valid = 1'b0;
    win_idx   = '0;
    for (int k = NUM_REQ - 1; k >= 0; k--) begin
      cand = IDX_W'((32'(base) + k) % NUM_REQ);
      if (pend[cand]) begin
        win_valid = 1'b1;
        win_idx   = cand;
      end
    end
  end

  AST_PRIO_PICK: assert property (@(posedge aclk) disable iff (!aresetn)
    (pend != '0) |-> (win_valid && pend[win_idx]))
    else $error("Encoder missed or picked a request that is not pending");

endmodule

// [viu_top.sv]
// Vectored interrupt unit: request latching, masking, priority, vector fetch.
// Assumes the core pulses instr_last in the last cycle of each instruction and
// program memory returns data one cycle after a read strobe.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
module viu_top (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite slave
  input  wire logic [viu_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [viu_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Request sources
  input  wire logic                       ext_request_pin_0,
  input  wire logic                       ext_request_pin_1,
  input  wire logic                       ext_request_pin_2,
  input  wire logic                       ext_request_pin_3,
  input  wire logic                       counter_timer_a,
  input  wire logic                       counter_timer_b,
  // Core handshake
  input  wire logic                       instr_last,
  output logic                            irq_to_core,
  output logic                            save_ctx,
  output logic                            vec_valid,
  output logic [viu_pkg::VEC_W-1:0]       vec_addr,
  output logic [viu_pkg::IDX_W-1:0]       grant_idx,
  // Program memory read port
  output logic                            pmem_rd,
  output logic [viu_pkg::VEC_W-1:0]       pmem_addr,
  input  wire logic [7:0]                 pmem_data,
  // RAM protect
  input  wire logic                       ram_protect_cycle,
  input  wire logic [7:0]                 reg_access_addr,
  output logic                            reg_access_denied,
  // Interrupt to the system
  output logic                            irq
);
  import viu_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [3:0]         pin_s1_r;
  logic [3:0]         pin_s2_r;
  logic [3:0]         pin_old_r;
  logic [NUM_REQ-1:0] hw_set;
  logic [NUM_REQ-1:0] req_r;
  logic [NUM_REQ-1:0] eligible;
  logic [7:0]         prio_r;
  logic [7:0]         mask_r;
  logic [EV_W-1:0]    evt_sts_r;
  logic [EV_W-1:0]    evt_msk_r;
  logic               ram_block_r;
  logic               win_valid;
  logic [IDX_W-1:0]   win_idx;
  logic               start;
  viu_state_t         state_r;
  logic [IDX_W-1:0]   idx_r;
  logic [7:0]         hi_r;
  logic [AXI_AW-1:0]  awaddr_r;
  logic [31:0]        wdata_r;
  logic [3:0]         wstrb_r;
  logic               aw_have_r;
  logic               w_have_r;
  logic               wr_go;
  logic               wr_hit;
  logic               wr_lane0;
  logic [7:0]         wr_byte;

  // ----------------------------------------------------------------------
  // Pin synchronisers and event detection
  // ----------------------------------------------------------------------
  // Two flops before anything looks at the pins; a rising edge is one event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r  <= 4'h0;
      pin_s2_r  <= 4'h0;
      pin_old_r <= 4'h0;
    end else begin
      pin_s1_r  <= {ext_request_pin_3, ext_request_pin_2, ext_request_pin_1, ext_request_pin_0};
      pin_s2_r  <= pin_s1_r;
      pin_old_r <= pin_s2_r;
    end
  end

  // Source to request routing
  always_comb begin
    hw_set           = '0;
    hw_set[PIN0_REQ] = pin_s2_r[0] & ~pin_old_r[0];
    hw_set[PIN1_REQ] = pin_s2_r[1] & ~pin_old_r[1];
    hw_set[PIN2_REQ] = pin_s2_r[2] & ~pin_old_r[2];
    hw_set[PIN3_REQ] = pin_s2_r[3] & ~pin_old_r[3];
    hw_set[TMRA_REQ] = counter_timer_a;
    hw_set[TMRB_REQ] = counter_timer_b;
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
  assign wr_go         = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_lane0      = wr_go && wstrb_r[0];
  assign wr_byte       = wdata_r[7:0];
  assign wr_hit        = (awaddr_r == ADDR_PRIO) || (awaddr_r == ADDR_REQ) ||
                         (awaddr_r == ADDR_MASK) || (awaddr_r == ADDR_EVT_STS) ||
                         (awaddr_r == ADDR_EVT_MSK);

  // Address and data are held separately so either may arrive first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
    end else if (wr_go) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[AXI_AW-1:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Reading has no side effects, so polling the request register is safe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case ({s_axi_araddr[AXI_AW-1:2], 2'b00})
        ADDR_PRIO:    s_axi_rdata <= {24'h0, prio_r};
        ADDR_REQ:     s_axi_rdata <= {26'h0, req_r};
        ADDR_MASK:    s_axi_rdata <= {24'h0, mask_r};
        ADDR_EVT_STS: s_axi_rdata <= {30'h0, evt_sts_r};
        ADDR_EVT_MSK: s_axi_rdata <= {30'h0, evt_msk_r};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Priority and mask registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prio_r <= PRIO_RST;
    end else if (wr_lane0 && awaddr_r == ADDR_PRIO) begin
      prio_r <= wr_byte;
    end
  end

  // The grant sequence clears the global enable; it overrides a write
  // so that no second request slips in before context is saved
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= MASK_RST;
    end else if (state_r == VIU_DIS) begin
      mask_r[MASK_GLOBAL_BIT] <= 1'b0;
    end else if (wr_lane0 && awaddr_r == ADDR_MASK) begin
      mask_r <= wr_byte;
    end
  end

  // ----------------------------------------------------------------------
  // Request register
  // ----------------------------------------------------------------------
  // Hardware sets win over software clears and over the grant clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_r <= REQ_RST;
    end else begin
      logic [NUM_REQ-1:0] base;
      base = req_r;
      if (wr_lane0 && awaddr_r == ADDR_REQ) begin
        base = wr_byte[NUM_REQ-1:0];
      end
      if (start) begin
        base[win_idx] = 1'b0;
      end
      req_r <= base | hw_set;
    end
  end

  // ----------------------------------------------------------------------
  // Setup age per request
  // ----------------------------------------------------------------------
  // A request only counts once it has stood for the setup time
  generate
    for (genvar i = 0; i < NUM_REQ; i++) begin : g_age
      logic [1:0] age_r;
      always_ff @(posedge aclk) begin
        if (!aresetn || !req_r[i]) begin
          age_r <= 2'h0;
        end else if (age_r != SETUP_CYC) begin
          age_r <= age_r + 2'h1;
        end
      end
      // Each request is enabled on its own and by the global bit
      assign eligible[i] = req_r[i] && (age_r == SETUP_CYC) && mask_r[i] &&
                           mask_r[MASK_GLOBAL_BIT];
    end
  endgenerate

  viu_prio u_prio (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pend      (eligible),
    .first     (prio_r[IDX_W-1:0]),
    .win_valid (win_valid),
    .win_idx   (win_idx)
  );

  // Requests are only sampled at the end of an instruction
  assign start       = (state_r == VIU_IDLE) && instr_last && win_valid;
  assign irq_to_core = (state_r == VIU_IDLE) && win_valid;

  // ----------------------------------------------------------------------
  // Grant sequence: block, save, fetch two vector bytes, jump
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= VIU_IDLE;
    end else begin
      case (state_r)
        VIU_IDLE: if (start) state_r <= VIU_DIS;
        VIU_DIS:  state_r <= VIU_SAV;
        VIU_SAV:  state_r <= VIU_FHI;
        VIU_FHI:  state_r <= VIU_FLO;
        VIU_FLO:  state_r <= VIU_LOAD;
        VIU_LOAD: state_r <= VIU_DONE;
        VIU_DONE: state_r <= VIU_IDLE;
        default:  state_r <= VIU_IDLE;
      endcase
    end
  end

  // Vector entry n sits at bytes 2n and 2n+1, high byte first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_r     <= '0;
      hi_r      <= 8'h0;
      pmem_addr <= 16'h0000;
      vec_addr  <= 16'h0000;
    end else begin
      if (start) idx_r <= win_idx;
      if (state_r == VIU_SAV) pmem_addr <= {12'h000, idx_r, 1'b0};
      if (state_r == VIU_FHI) pmem_addr <= {12'h000, idx_r, 1'b1};
      if (state_r == VIU_FLO) hi_r <= pmem_data;
      if (state_r == VIU_LOAD) vec_addr <= {hi_r, pmem_data};
    end
  end

  assign save_ctx  = (state_r == VIU_SAV);
  assign pmem_rd   = (state_r == VIU_FHI) || (state_r == VIU_FLO);
  assign vec_valid = (state_r == VIU_DONE);
  assign grant_idx = idx_r;

  // ----------------------------------------------------------------------
  // RAM protect
  // ----------------------------------------------------------------------
  // Protect only takes hold if armed first; once set it lasts until reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ram_block_r       <= 1'b0;
      reg_access_denied <= 1'b0;
    end else begin
      if (ram_protect_cycle && mask_r[MASK_RAMPROT_BIT]) ram_block_r <= 1'b1;
      reg_access_denied <= ram_block_r && (reg_access_addr >= RAM_UPPER_LO) &&
                           (reg_access_addr < CTRL_REG_LO);
    end
  end

  // ----------------------------------------------------------------------
  // Event status, mask and system interrupt
  // ----------------------------------------------------------------------
  // Write one to clear; a new event in the same cycle stays set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_sts_r <= EV_RST;
      evt_msk_r <= EV_RST;
    end else begin
      logic [EV_W-1:0] ev;
      logic [EV_W-1:0] clr;
      ev           = '0;
      ev[EV_GRANT] = start;
      ev[EV_POLL]  = |(hw_set & ~mask_r[NUM_REQ-1:0]);
      clr          = (wr_lane0 && awaddr_r == ADDR_EVT_STS) ? wr_byte[EV_W-1:0] : '0;
      evt_sts_r    <= (evt_sts_r & ~clr) | ev;
      if (wr_lane0 && awaddr_r == ADDR_EVT_MSK) evt_msk_r <= wr_byte[EV_W-1:0];
    end
  end

  assign irq = |(evt_sts_r & evt_msk_r);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_GLOBAL_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == VIU_DIS) |=> !mask_r[MASK_GLOBAL_BIT] && save_ctx)
    else $error("Global enable not cleared before context save");

  AST_SEQ_ORDER: assert property (@(posedge aclk) disable iff (!aresetn)
    save_ctx |-> ##1 pmem_rd ##1 pmem_rd ##2 vec_valid)
    else $error("Grant sequence out of order");

  AST_VEC_ADDR: assert property (@(posedge aclk) disable iff (!aresetn)
    vec_valid |-> vec_addr == {$past(pmem_data, 2), $past(pmem_data, 1)})
    else $error("Vector not assembled from the two fetched bytes");

  AST_VEC_LOC: assert property (@(posedge aclk) disable iff (!aresetn)
    (pmem_rd && !$past(pmem_rd)) |-> pmem_addr == {12'h000, grant_idx, 1'b0})
    else $error("Vector fetch from wrong location");

  AST_GRANT_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
    (start && !hw_set[win_idx]) |=> !req_r[idx_r])
    else $error("Granted request left pending");

  AST_ENABLED: assert property (@(posedge aclk) disable iff (!aresetn)
    start |-> mask_r[MASK_GLOBAL_BIT] && mask_r[win_idx])
    else $error("Disabled request was granted");

  AST_SETUP: assert property (@(posedge aclk) disable iff (!aresetn)
    start |-> instr_last &&
      (($past(req_r, 2) & $past(req_r, 1) & (6'h01 << win_idx)) != 6'h00))
    else $error("Request granted without setup time or outside instruction end");

  AST_RECORD: assert property (@(posedge aclk) disable iff (!aresetn)
    (hw_set != '0) |=> (req_r & $past(hw_set)) == $past(hw_set))
    else $error("Hardware request not recorded");

  AST_TIMER_MAP: assert property (@(posedge aclk) disable iff (!aresetn)
    counter_timer_b |=> req_r[TMRB_REQ])
    else $error("Timer b did not raise its request");

  AST_RAM_ARM: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ram_block_r) |-> $past(mask_r[MASK_RAMPROT_BIT]) && $past(ram_protect_cycle))
    else $error("RAM protect took hold without being armed");

endmodule

// [viu_pmem_model.sv]
// Program memory model holding the vector table of the unit.
// Assumes one byte is read per strobe and returned in the next cycle.
`timescale 1ns/10ps
module viu_pmem_model (
  // Clock
  input  wire logic                     aclk,
  // Read port
  input  wire logic                     pmem_rd,
  input  wire logic [viu_pkg::VEC_W-1:0] pmem_addr,
  output logic      [7:0]               pmem_data
);
  import viu_pkg::*;
  initial pmem_data = 8'h00;
  // Byte answers a strobe; an idle bus toggles so stale data never looks valid
  always @(posedge aclk) begin
    pmem_data <= pmem_rd ? {pmem_addr[3:0], ~pmem_addr[3:0]} : ~pmem_data;
  end
endmodule

// [vectored_interrupt_unit_tb.sv]
// Self-checking bench of the vectored interrupt unit.
// Assumes viu_pkg, the design and the memory model are compiled first.
`timescale 1ns/10ps
module vectored_interrupt_unit_tb;
  import viu_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic              aclk = 0, aresetn = 0, instr_last = 0, ram_protect_cycle = 0;
  logic [AXI_AW-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0]       s_axi_wdata = 0, s_axi_rdata;
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic              s_axi_bready = 1, s_axi_rready = 1;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [5:0]        src = 0, r;
  logic [7:0]        reg_access_addr = 0, pmem_data;
  logic [15:0]       vec_addr, pmem_addr;
  logic [2:0]        grant_idx, p;
  logic              vec_valid, pmem_rd, reg_access_denied, irq, irq_to_core;
  logic [31:0]       seed = 32'h0000D7C7;
  logic [33:0]       q[$];
  int                errors = 0, samples_checked = 0, w;
  int                map[6] = '{3, 2, 0, 1, 4, 5};
  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;
  viu_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_request_pin_0(src[0]), .ext_request_pin_1(src[1]),
    .ext_request_pin_2(src[2]), .ext_request_pin_3(src[3]), .counter_timer_a(src[4]),
    .counter_timer_b(src[5]), .instr_last, .irq_to_core, .save_ctx(), .vec_valid,
    .vec_addr, .grant_idx, .pmem_rd, .pmem_addr, .pmem_data, .ram_protect_cycle,
    .reg_access_addr, .reg_access_denied, .irq);
  viu_pmem_model mem (.aclk, .pmem_rd, .pmem_addr, .pmem_data);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Rotating order: start at the priority field, values above five start at zero
  function automatic int win(input logic [5:0] rq, input logic [2:0] pr);
    int s;
    s = (pr > 5) ? 0 : pr;
    for (int k = 0; k < 6; k++) if (rq[(s + k) % 6]) return (s + k) % 6;
    return 0;
  endfunction
  function automatic logic [15:0] vexp(input int n);
    logic [3:0] a;
    a = 4'(2 * n);
    return {a, ~a, a + 4'h1, ~(a + 4'h1)};
  endfunction
  // Ready is looked at before the edge, so the race with the slave's update is avoided
  task automatic wr(input logic [AXI_AW-1:0] a, input logic [7:0] d);
    logic ao, wo, bo;
    ao = 0;
    wo = 0;
    bo = 0;
    q.push_back({RESP_OKAY, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    repeat (40) if (!bo) begin
      @(negedge aclk);
      ao = ao | s_axi_awready;
      wo = wo | s_axi_wready;
      bo = s_axi_bvalid;
      @(posedge aclk);
      // Each valid is lowered once, on its own taking edge, so the next call may raise it
      if (ao && s_axi_awvalid) s_axi_awvalid <= 0;
      if (wo && s_axi_wvalid) s_axi_wvalid <= 0;
    end
    if (!bo) errors++;
  endtask
  task automatic rd(input logic [AXI_AW-1:0] a, input logic [33:0] e);
    logic ro, vo;
    ro = 0;
    vo = 0;
    q.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    repeat (40) if (!vo) begin
      @(negedge aclk);
      ro = ro | s_axi_arready;
      vo = s_axi_rvalid;
      @(posedge aclk);
      if (ro && s_axi_arvalid) s_axi_arvalid <= 0;
    end
    if (!vo) errors++;
  endtask
  // ----------------------------------------------------------------------
  // Result watcher and watchdog
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, q.pop_front());
    if (s_axi_bvalid && s_axi_bready) check({s_axi_bresp, 32'h0}, q.pop_front());
    if (vec_valid) check({15'h0, grant_idx, vec_addr}, q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    finish_test();
  end
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(ADDR_MASK, 34'h0);
    rd(ADDR_REQ, 34'h0);
    rd(12'h010, {RESP_SLVERR, 32'h0});
    // Protect cycle is ignored until armed, then blocks the upper half but not the control registers
    reg_access_addr <= 8'h80;
    ram_protect_cycle <= 1;
    @(posedge aclk);
    ram_protect_cycle <= 0;
    repeat (2) @(posedge aclk);
    check(reg_access_denied, 0);
    wr(ADDR_MASK, 8'h40);
    ram_protect_cycle <= 1;
    @(posedge aclk);
    ram_protect_cycle <= 0;
    repeat (2) @(posedge aclk);
    check(reg_access_denied, 1);
    reg_access_addr <= 8'hF0;
    repeat (2) @(posedge aclk);
    check(reg_access_denied, 0);
    // Each source lands on its own request bit while everything is masked
    wr(ADDR_MASK, 8'h00);
    for (int i = 0; i < 6; i++) begin
      src <= 6'h01 << i;
      @(posedge aclk);
      if (i > 3) src <= 0;
      repeat (5) @(posedge aclk);
      src <= 0;
      rd(ADDR_REQ, 34'h1 << map[i]);
      wr(ADDR_REQ, 8'h00);
    end
    rd(ADDR_EVT_STS, 34'h2);
    wr(ADDR_EVT_STS, 8'h03);
    // Software requests under every priority setting
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      r = seed[5:0] | (6'h01 << (i % 6));
      p = 3'(i);
      w = win(r, p);
      wr(ADDR_PRIO, {5'h0, p});
      wr(ADDR_MASK, 8'hBF);
      wr(ADDR_REQ, {2'h0, r});
      q.push_back({15'h0, 3'(w), vexp(w)});
      repeat (4) @(posedge aclk);
      check(irq_to_core, 1);
      instr_last <= 1;
      @(posedge aclk);
      instr_last <= 0;
      repeat (10) @(posedge aclk);
      rd(ADDR_REQ, {28'h0, r & ~(6'h01 << w)});
      rd(ADDR_MASK, 34'h3F);
    end
    // Grant event raises the interrupt only while unmasked
    wr(ADDR_EVT_MSK, 8'h01);
    check(irq, 1);
    wr(ADDR_EVT_MSK, 8'h00);
    check(irq, 0);
    wr(ADDR_EVT_STS, 8'h03);
    wr(ADDR_EVT_MSK, 8'h03);
    check(irq, 0);
    wait (q.size() == 0);
    repeat (2) @(posedge aclk);
    finish_test();
  end
endmodule
